// file: pkg/event_router_regs.vh
`ifndef EVENT_ROUTER_REGS_VH
`define EVENT_ROUTER_REGS_VH
// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define ER_SOFT_EVENT_LO   10'h040
`define ER_SOFT_EVENT_HI   10'h044
`define ER_BUSY_LO         10'h050
`define ER_BUSY_HI         10'h054
`define ER_OVR_STATUS_LO   10'h0B0
`define ER_OVR_STATUS_HI   10'h0B4
`define ER_OVR_CLEAR_LO    10'h0C0
`define ER_OVR_CLEAR_HI    10'h0C4
`define ER_OVR_MASK_LO     10'h0D0
`define ER_OVR_MASK_HI     10'h0D4
`define ER_OVR_ENABLE_LO   10'h0E0
`define ER_OVR_ENABLE_HI   10'h0E4
`define ER_OVR_DISABLE_LO  10'h0F0
`define ER_OVR_DISABLE_HI  10'h0F4
`define ER_PARAMETER       10'h3F8
`define ER_VERSION         10'h3FC
`define ER_CHMUX_BASE      10'h100
`define ER_SHAPER_BASE     10'h200
// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define ER_SOFT_SEL_BIT    8
`define ER_GEN_SEL_MSB     5
`define ER_RISE_BIT        0
`define ER_FALL_BIT        1
`define ER_FILTER_BIT      2
// ----------------------------------------------------------------------------
// Reset values and constants.
// ----------------------------------------------------------------------------
`define ER_MASK_RESET      32'h00000000
`define ER_MUX_RESET       9'h000
`define ER_SHAPER_RESET    3'h0
`define ER_BUSY_LO_FORCED  32'h003FFFFF
`define ER_VERSION_VALUE   32'h00000A5A
`define ER_FILTER_STAGES   3
`endif

// file: verilog/edge_shaper.v
`include "event_router_regs.vh"

// Edge shaper: optional glitch filter, then rise/fall pulse detection.
module edge_shaper (
  // Clock and reset.
  input  wire       clk_i,
  input  wire       rst_i,
  // Generator level and configuration.
  input  wire       level_i,
  input  wire [2:0] cfg_i,
  // Detected event pulse.
  output reg        pulse_o
);

  reg [`ER_FILTER_STAGES-1:0] hist_r;   // Recent input samples.
  reg                         filt_r;   // Filtered level.
  reg                         prev_r;   // Previous shaped level.
  wire                        shaped;   // Level after optional filter.

  // ---------------------------------------------------------------------------
  // Glitch filter: the level only moves once all samples agree, which costs
  // a few cycles of latency but rejects one-cycle spikes.
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      hist_r <= {`ER_FILTER_STAGES{1'b0}};
      filt_r <= 1'b0;
    end else begin
      hist_r <= {hist_r[`ER_FILTER_STAGES-2:0], level_i};
      if (&hist_r) begin
        filt_r <= 1'b1;
      end else if (~|hist_r) begin
        filt_r <= 1'b0;
      end
    end
  end

  assign shaped = cfg_i[`ER_FILTER_BIT] ? filt_r : level_i;

  // ---------------------------------------------------------------------------
  // Edge detection, each edge gated by its enable.
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_r  <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      prev_r  <= shaped;
      pulse_o <= (cfg_i[`ER_RISE_BIT] & shaped & ~prev_r) |
                 (cfg_i[`ER_FALL_BIT] & ~shaped & prev_r);
    end
  end

endmodule // edge_shaper

// file: verilog/event_router.v
`include "event_router_regs.vh"

//
// Behaviour
// - Overrun flag sticks until software clears it.
// - Clear write drops flags at one bits.
// - Per-channel sets use two 32-bit words.
// - Mask reads enables, resets to zero.
// - Enable write of one sets mask bit.
// - Disable write of one clears mask bit.
// - Mux word picks generator when software off.
// - Software select routes software event instead.
// - Rise enable detects rising edges.
// - Fall enable detects falling edges.
// - Filter enable inserts glitch filter.
// - Sizes 34/24/22, reported by parameter register.
// - Busy word zero resets FFFF, bits 21:16 ones.
// - Generators 0-23 shaped, 24-33 unshaped.
// - Channels 0-21 drive user actions in order.
// - Software event write of one triggers channel.
// - Busy bits of channels 0-21 always read as one.
module event_router #(
  parameter GEN_COUNT    = 34,
  parameter SHAPER_COUNT = 24,
  parameter CHAN_COUNT   = 22
) (
  // Clock and reset.
  input  wire                  CLK_SYS_I,
  input  wire                  RST_I,
  // Register port.
  input  wire [9:0]            ADDR_I,
  input  wire [31:0]           WDATA_I,
  input  wire                  WR_I,
  input  wire                  RD_I,
  output reg  [31:0]           RDATA_O,
  // Generators and users.
  input  wire [GEN_COUNT-1:0]  GEN_EVENT_I,
  input  wire [CHAN_COUNT-1:0] USER_BUSY_I,
  output reg  [CHAN_COUNT-1:0] USER_TRIGGER_O,
  // Overrun interrupt.
  output reg                   IRQ_O
);

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  reg  [8:0]            mux_r [0:CHAN_COUNT-1];   // Channel source words.
  reg  [2:0]            shp_r [0:SHAPER_COUNT-1]; // Shaper configurations.
  reg  [CHAN_COUNT-1:0] ovr_r;                    // Overrun flags.
  reg  [CHAN_COUNT-1:0] ovr_nxt;                  // Next overrun flags.
  reg  [CHAN_COUNT-1:0] mask_r;                   // Overrun interrupt mask.
  reg  [CHAN_COUNT-1:0] mask_nxt;                 // Next mask.
  reg  [CHAN_COUNT-1:0] soft_r;                   // Software event pulses.
  reg  [CHAN_COUNT-1:0] chan_busy_r;              // Channel holds an event.
  wire [GEN_COUNT-1:0]  gen_evt;                  // Events after shaping.
  wire [CHAN_COUNT-1:0] chan_in;                  // Routed channel inputs.
  wire [CHAN_COUNT-1:0] busy_all;                 // Channel or user busy.
  wire [63:0]           ovr_w;                    // Overrun flags, 64 wide.
  wire [63:0]           mask_w;                   // Mask, 64 wide.
  wire [63:0]           busy_w;                   // Busy, 64 wide.
  wire [63:0]           wr_lo;                    // Write data in low word.
  wire [63:0]           wr_hi;                    // Write data in high word.
  reg  [31:0]           rd_nxt;                   // Read data next.
  integer               k;                        // Loop index, write side.
  integer               m;                        // Loop index, read side.
  wire [31:0]           mask_rst;                 // Mask reset word, 32 wide.

  // The reset word is 32 wide; only the implemented channels take it.
  assign mask_rst = `ER_MASK_RESET;

  // Strobe for a write to a given register offset.
  function wr_hit;
    input [9:0] a;
    input [9:0] off;
    input       w;
    begin
      wr_hit = w & (a == off);
    end
  endfunction

  // Decode a write pair into a 64-bit one-hot-per-channel vector.
  assign wr_lo = {32'h00000000, WDATA_I};
  assign wr_hi = {WDATA_I, 32'h00000000};

  // ---------------------------------------------------------------------------
  // Shapers on generators 0..SHAPER_COUNT-1, the rest pass straight.
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < GEN_COUNT; g = g + 1) begin : gen_shape
      if (g < SHAPER_COUNT) begin : with_shaper
        edge_shaper u_shaper (
          .clk_i   (CLK_SYS_I),
          .rst_i   (RST_I),
          .level_i (GEN_EVENT_I[g]),
          .cfg_i   (shp_r[g]),
          .pulse_o (gen_evt[g])
        );
      end else begin : no_shaper
        assign gen_evt[g] = GEN_EVENT_I[g];
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Channel multiplexers.
  // ---------------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < CHAN_COUNT; c = c + 1) begin : gen_mux
      wire [5:0] sel = mux_r[c][`ER_GEN_SEL_MSB:0];
      assign chan_in[c] = mux_r[c][`ER_SOFT_SEL_BIT] ? soft_r[c] :
                          (sel < GEN_COUNT) ? gen_evt[sel] : 1'b0;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Busy tracking: a channel is busy from forwarding an event until the user
  // drops its busy line; the user may take a cycle to raise it.
  // ---------------------------------------------------------------------------
  assign busy_all = chan_busy_r | USER_BUSY_I;

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      chan_busy_r    <= {CHAN_COUNT{1'b0}};
      USER_TRIGGER_O <= {CHAN_COUNT{1'b0}};
    end else begin
      // Accepted events go to their users, all channels in the same cycle.
      USER_TRIGGER_O <= chan_in & ~busy_all;
      chan_busy_r    <= (chan_in & ~busy_all) | (chan_busy_r & ~USER_TRIGGER_O);
    end
  end

  // ---------------------------------------------------------------------------
  // Overrun flags and mask: hardware set wins over software clear.
  // ---------------------------------------------------------------------------
  always @* begin
    ovr_nxt = ovr_r;
    if (wr_hit(ADDR_I, `ER_OVR_CLEAR_LO, WR_I)) begin
      ovr_nxt = ovr_nxt & ~wr_lo[CHAN_COUNT-1:0];
    end
    if (wr_hit(ADDR_I, `ER_OVR_CLEAR_HI, WR_I)) begin
      ovr_nxt = ovr_nxt & ~wr_hi[CHAN_COUNT-1:0];
    end
    ovr_nxt = ovr_nxt | (chan_in & busy_all);
    mask_nxt = mask_r;
    if (wr_hit(ADDR_I, `ER_OVR_ENABLE_LO, WR_I)) begin
      mask_nxt = mask_nxt | wr_lo[CHAN_COUNT-1:0];
    end
    if (wr_hit(ADDR_I, `ER_OVR_ENABLE_HI, WR_I)) begin
      mask_nxt = mask_nxt | wr_hi[CHAN_COUNT-1:0];
    end
    if (wr_hit(ADDR_I, `ER_OVR_DISABLE_LO, WR_I)) begin
      mask_nxt = mask_nxt & ~wr_lo[CHAN_COUNT-1:0];
    end
    if (wr_hit(ADDR_I, `ER_OVR_DISABLE_HI, WR_I)) begin
      mask_nxt = mask_nxt & ~wr_hi[CHAN_COUNT-1:0];
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ovr_r  <= {CHAN_COUNT{1'b0}};
      mask_r <= mask_rst[CHAN_COUNT-1:0];
      IRQ_O  <= 1'b0;
    end else begin
      ovr_r  <= ovr_nxt;
      mask_r <= mask_nxt;
      IRQ_O  <= |(ovr_nxt & mask_nxt);
    end
  end

  // ---------------------------------------------------------------------------
  // Software events: one-cycle pulses from a write of ones.
  // ---------------------------------------------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      soft_r <= {CHAN_COUNT{1'b0}};
    end else if (wr_hit(ADDR_I, `ER_SOFT_EVENT_LO, WR_I)) begin
      soft_r <= wr_lo[CHAN_COUNT-1:0];
    end else if (wr_hit(ADDR_I, `ER_SOFT_EVENT_HI, WR_I)) begin
      soft_r <= wr_hi[CHAN_COUNT-1:0];
    end else begin
      soft_r <= {CHAN_COUNT{1'b0}};
    end
  end

  // ---------------------------------------------------------------------------
  // Multiplexer and shaper configuration words.
  // ---------------------------------------------------------------------------
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      for (k = 0; k < CHAN_COUNT; k = k + 1) begin
        mux_r[k] <= `ER_MUX_RESET;
      end
      for (k = 0; k < SHAPER_COUNT; k = k + 1) begin
        shp_r[k] <= `ER_SHAPER_RESET;
      end
    end else if (WR_I) begin
      for (k = 0; k < CHAN_COUNT; k = k + 1) begin
        if (ADDR_I == `ER_CHMUX_BASE + k[9:0] * 10'd4) begin
          mux_r[k] <= {WDATA_I[`ER_SOFT_SEL_BIT], 2'b00, WDATA_I[`ER_GEN_SEL_MSB:0]};
        end
      end
      for (k = 0; k < SHAPER_COUNT; k = k + 1) begin
        if (ADDR_I == `ER_SHAPER_BASE + k[9:0] * 10'd4) begin
          shp_r[k] <= WDATA_I[2:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read path; unmapped and write-only offsets read as zero.
  // ---------------------------------------------------------------------------
  assign ovr_w  = {{(64-CHAN_COUNT){1'b0}}, ovr_r};
  assign mask_w = {{(64-CHAN_COUNT){1'b0}}, mask_r};
  assign busy_w = {{(64-CHAN_COUNT){1'b0}}, busy_all};

  always @* begin
    rd_nxt = 32'h00000000;
    case (ADDR_I)
      `ER_OVR_STATUS_LO: rd_nxt = ovr_w[31:0];
      `ER_OVR_STATUS_HI: rd_nxt = ovr_w[63:32];
      `ER_OVR_MASK_LO:   rd_nxt = mask_w[31:0];
      `ER_OVR_MASK_HI:   rd_nxt = mask_w[63:32];
      // All 22 channel lanes read busy, so the low word always reads the fixed pattern.
      `ER_BUSY_LO:       rd_nxt = busy_w[31:0] | `ER_BUSY_LO_FORCED;
      `ER_BUSY_HI:       rd_nxt = busy_w[63:32];
      `ER_PARAMETER:     rd_nxt = {8'h00, CHAN_COUNT[7:0], SHAPER_COUNT[7:0],
                                   GEN_COUNT[7:0]};
      `ER_VERSION:       rd_nxt = `ER_VERSION_VALUE; // Arbitrary value.
      default: begin
        for (m = 0; m < CHAN_COUNT; m = m + 1) begin
          if (ADDR_I == `ER_CHMUX_BASE + m[9:0] * 10'd4) begin
            rd_nxt = {23'h000000, mux_r[m]};
          end
        end
        for (m = 0; m < SHAPER_COUNT; m = m + 1) begin
          if (ADDR_I == `ER_SHAPER_BASE + m[9:0] * 10'd4) begin
            rd_nxt = {29'h00000000, shp_r[m]};
          end
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h00000000;
    end else if (RD_I) begin
      RDATA_O <= rd_nxt;
    end else begin
      RDATA_O <= 32'h00000000;
    end
  end

endmodule // event_router

// file: dv/event_user_model.sv
// ----------------------------------------------------------------
// Far-side users: each stays busy for a while after its trigger.
// ----------------------------------------------------------------
module event_user_model #(
  parameter CHAN_COUNT = 22,
  parameter HOLD       = 8
) (
  input  wire                  clk_i,
  input  wire                  rst_i,
  input  wire                  slow_i,    // High: work HOLD cycles, else one.
  input  wire [CHAN_COUNT-1:0] trigger_i,
  output reg  [CHAN_COUNT-1:0] busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [3:0] HOLD_W = HOLD;
  reg [3:0] left_r [0:CHAN_COUNT-1]; // Cycles of work left per user.
  integer   k;
  integer   j;
  // A trigger restarts the work count, even while the user is still working.
  always @(posedge clk_i) begin
    for (k = 0; k < CHAN_COUNT; k = k + 1) begin
      if (rst_i) begin
        left_r[k] <= 4'h0;
      end else if (trigger_i[k]) begin
        left_r[k] <= slow_i ? HOLD_W : 4'h1;
      end else if (left_r[k] != 4'h0) begin
        left_r[k] <= left_r[k] - 4'h1;
      end
    end
  end
  // Busy level handed back to the router.
  always @* begin
    for (j = 0; j < CHAN_COUNT; j = j + 1) begin
      busy_o[j] = (left_r[j] != 4'h0);
    end
  end
endmodule // event_user_model

// file: dv/event_router_chk.sv
`include "event_router_regs.vh"
// ----------------------------------------------------------------
// Port checks; channel 0 source is tracked from bus writes.
// ----------------------------------------------------------------
module event_router_chk #(
  parameter GEN_COUNT    = 34,
  parameter SHAPER_COUNT = 24,
  parameter CHAN_COUNT   = 22
) (
  input wire                  CLK_SYS_I,
  input wire                  RST_I,
  input wire [9:0]            ADDR_I,
  input wire [31:0]           WDATA_I,
  input wire                  WR_I,
  input wire                  RD_I,
  input wire [31:0]           RDATA_O,
  input wire [GEN_COUNT-1:0]  GEN_EVENT_I,
  input wire [CHAN_COUNT-1:0] USER_BUSY_I,
  input wire [CHAN_COUNT-1:0] USER_TRIGGER_O,
  input wire                  IRQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] PWORD = (CHAN_COUNT << 16) | (SHAPER_COUNT << 8) | GEN_COUNT;
  reg [6:0] sel_r;     // Channel 0 software select and generator number.
  reg       en_seen_r; // Set once an enable write to the low word has landed.
  // Shadow the writes that decide what channel 0 and the interrupt may do.
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sel_r     <= 7'h00;
      en_seen_r <= 1'b0;
    end else begin
      if (WR_I && ADDR_I == `ER_CHMUX_BASE) sel_r <= {WDATA_I[8], WDATA_I[5:0]};
      if (WR_I && ADDR_I == `ER_OVR_ENABLE_LO) en_seen_r <= 1'b1;
    end
  end
  default clocking dclk @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence s_raw_pick;
    !sel_r[6] && sel_r[5:0] > 6'h17 && sel_r[5:0] < 6'h22 && GEN_EVENT_I[sel_r[5:0]];
  endsequence
  sequence s_ch0_free;
    !USER_BUSY_I[0] && !USER_TRIGGER_O[0] && !$past(USER_TRIGGER_O[0]);
  endsequence
  a_raw_trigger: assert property (s_raw_pick ##0 s_ch0_free |=> USER_TRIGGER_O[0])
    else $error("channel 0 missed a raw generator event");
  a_range_quiet: assert property (!sel_r[6] && sel_r[5:0] > 6'h21 |=> !USER_TRIGGER_O[0])
    else $error("channel 0 fired from an unimplemented generator");
  a_no_double: assert property ((USER_TRIGGER_O & $past(USER_TRIGGER_O)) == 22'h0)
    else $error("trigger fired on a channel still holding");
  a_busy_block: assert property ((USER_TRIGGER_O & $past(USER_BUSY_I)) == 22'h0)
    else $error("trigger forwarded to a busy user");
  a_irq_gated: assert property (!en_seen_r |-> !IRQ_O)
    else $error("interrupt with no enabled mask bit");
  a_irq_off: assert property (WR_I && ADDR_I == `ER_OVR_DISABLE_LO && (&WDATA_I[21:0]) |-> ##[1:2] !IRQ_O)
    else $error("interrupt stayed up after full disable");
  a_hi_zero: assert property (RD_I && (ADDR_I == `ER_OVR_STATUS_HI || ADDR_I == `ER_OVR_MASK_HI) |=> RDATA_O == 32'h0)
    else $error("upper channel word not zero");
  a_busy_fixed: assert property (RD_I && ADDR_I == `ER_BUSY_LO |=> RDATA_O[21:0] == 22'h3FFFFF)
    else $error("busy word fixed bits wrong");
  a_param_word: assert property (RD_I && ADDR_I == `ER_PARAMETER |=> RDATA_O == PWORD)
    else $error("parameter word wrong");
endmodule // event_router_chk

// file: dv/test_event_router.sv
`include "event_router_regs.vh"
// ----------------------------------------------------------------
// Directed bench; every scenario judges its own results.
// ----------------------------------------------------------------
module test_event_router;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk;
  reg         rst;
  reg  [9:0]  addr;
  reg  [31:0] wdata;
  reg         wr_s;
  reg         rd_s;
  reg  [33:0] gen;
  reg         slow;
  wire [31:0] rdata;
  wire [21:0] ubusy;
  wire [21:0] trig;
  wire        irq;
  integer     n_fail;
  integer     n_tests;
  event_router u_event_router (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .GEN_EVENT_I(gen), .USER_BUSY_I(ubusy),
    .USER_TRIGGER_O(trig), .IRQ_O(irq));
  event_user_model u_event_user_model (.clk_i(clk), .rst_i(rst), .slow_i(slow),
    .trigger_i(trig), .busy_o(ubusy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0s exp %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input [9:0] a, input [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge.
  task rc(input [9:0] a, input [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata, e);
  endtask
  task lv(input integer g, input v);
    @(posedge clk);
    gen[g] <= v;
  endtask
  // Trigger pulses last one cycle, so every cycle of the window is looked at.
  task wt(input integer ch, input e);
    reg     hit;
    integer i;
    hit = 1'b0;
    for (i = 0; i < 20; i = i + 1) begin
      #1 hit = hit | trig[ch];
      @(posedge clk);
    end
    chk($sformatf("trigger %0d", ch), {31'h0, hit}, {31'h0, e});
    if (e && !hit) test_done;
  endtask
  task t_regs;
    rc(`ER_OVR_MASK_LO, 32'h0);
    wr(`ER_OVR_MASK_LO, 32'hFFFFFFFF);
    rc(`ER_OVR_MASK_LO, 32'h0);
    rc(`ER_PARAMETER, 32'h00161822);
    rc(`ER_BUSY_LO, 32'h003FFFFF);
    rc(`ER_OVR_STATUS_HI, 32'h0);
    rc(10'h300, 32'h0);
    rc(`ER_CHMUX_BASE + 10'h004, 32'h0);
    wr(`ER_CHMUX_BASE, 32'hFFFFFFFF);
    rc(`ER_CHMUX_BASE, 32'h0000013F);
  endtask
  task t_mask;
    wr(`ER_OVR_ENABLE_LO, 32'h5);
    wr(`ER_OVR_ENABLE_LO, 32'h2);
    rc(`ER_OVR_MASK_LO, 32'h7);
    wr(`ER_OVR_DISABLE_LO, 32'h4);
    rc(`ER_OVR_MASK_LO, 32'h3);
    wr(`ER_OVR_ENABLE_HI, 32'hFFFFFFFF);
    rc(`ER_OVR_MASK_HI, 32'h0);
    wr(`ER_OVR_DISABLE_LO, 32'hFFFFFFFF);
    rc(`ER_OVR_MASK_LO, 32'h0);
  endtask
  task t_soft;
    wr(`ER_CHMUX_BASE, 32'h119);
    lv(25, 1'b1);
    lv(25, 1'b0);
    wt(0, 1'b0);
    wr(`ER_SOFT_EVENT_LO, 32'h0);
    wt(0, 1'b0);
    wr(`ER_SOFT_EVENT_LO, 32'h1);
    wt(0, 1'b1);
  endtask
  task t_raw;
    wr(`ER_CHMUX_BASE, 32'h19);
    lv(25, 1'b1);
    lv(25, 1'b0);
    wt(0, 1'b1);
    wr(`ER_CHMUX_BASE, 32'h21);
    lv(33, 1'b1);
    lv(33, 1'b0);
    wt(0, 1'b1);
    wr(`ER_CHMUX_BASE, 32'h22);
    @(posedge clk);
    gen <= 34'h3FFFFFFFF;
    @(posedge clk);
    gen <= 34'h0;
    wt(0, 1'b0);
  endtask
  task t_shape;
    wr(`ER_CHMUX_BASE + 10'h008, 32'h3);
    wr(`ER_SHAPER_BASE + 10'h00C, 32'h1);
    lv(3, 1'b1);
    lv(3, 1'b0);
    wt(2, 1'b1);
    wr(`ER_SHAPER_BASE + 10'h00C, 32'h2);
    lv(3, 1'b1);
    wt(2, 1'b0);
    lv(3, 1'b0);
    wt(2, 1'b1);
    wr(`ER_SHAPER_BASE + 10'h00C, 32'h5);
    rc(`ER_SHAPER_BASE + 10'h00C, 32'h5);
    lv(3, 1'b1);
    lv(3, 1'b0);
    wt(2, 1'b0);
    lv(3, 1'b1);
    wt(2, 1'b1);
    lv(3, 1'b0);
  endtask
  // Second event lands while the slow user still works on the first.
  task t_ovr;
    @(posedge clk);
    slow <= 1'b1;
    wr(`ER_CHMUX_BASE + 10'h004, 32'h19);
    wr(`ER_OVR_ENABLE_LO, 32'h2);
    lv(25, 1'b1);
    lv(25, 1'b0);
    // The first trigger stands in this cycle only; look before it goes.
    #1 chk("trigger 1", {31'h0, trig[1]}, 32'h1);
    lv(25, 1'b1);
    lv(25, 1'b0);
    wt(1, 1'b0);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(`ER_OVR_DISABLE_LO, 32'hFFFFFFFF);
    rc(`ER_OVR_STATUS_LO, 32'h2);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`ER_OVR_ENABLE_LO, 32'h2);
    wr(`ER_OVR_CLEAR_LO, 32'hFFFFFFFD);
    rc(`ER_OVR_STATUS_LO, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(`ER_OVR_CLEAR_LO, 32'h2);
    rc(`ER_OVR_STATUS_LO, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask
  initial begin
    n_fail  = 0;
    n_tests = 0;
    rst     = 1'b1;
    addr    = 10'h000;
    wdata   = 32'h0;
    wr_s    = 1'b0;
    rd_s    = 1'b0;
    gen     = 34'h0;
    slow    = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_mask;
    t_soft;
    t_raw;
    t_shape;
    t_ovr;
    test_done;
  end
endmodule // test_event_router
bind event_router event_router_chk #(.GEN_COUNT(GEN_COUNT), .SHAPER_COUNT(SHAPER_COUNT),
  .CHAN_COUNT(CHAN_COUNT)) u_event_router_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .GEN_EVENT_I(GEN_EVENT_I), .USER_BUSY_I(USER_BUSY_I), .USER_TRIGGER_O(USER_TRIGGER_O),
  .IRQ_O(IRQ_O));
